// file: core/ssf_pkg.sv
// shared constants for the serial port status flag block
package ssf_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] SSF_ADDR_STATUS     = 8'h00;
    localparam logic [7:0] SSF_ADDR_CONTROL    = 8'h04;
    localparam logic [7:0] SSF_ADDR_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] SSF_ADDR_IRQ_CLEAR  = 8'h0C;
    localparam logic [7:0] SSF_ADDR_IRQ_STATUS = 8'h10;

    // serial_port_status field layout
    localparam int SSF_CNT_W        = 5;
    localparam int SSF_RXCNT_LSB    = 24;
    localparam int SSF_TXCNT_LSB    = 16;
    localparam int SSF_FRAME_ERROR_FLAG_BIT   = 12;
    localparam int SSF_BUSY_BIT     = 11;
    localparam int SSF_TUR_BIT      = 8;
    localparam int SSF_SHIFT_REG_EMPTY_FLAG_BIT     = 7;
    localparam int SSF_ROV_BIT      = 6;
    localparam int SSF_RBE_BIT      = 5;
    localparam int SSF_TBE_BIT      = 3;
    localparam int SSF_TBF_BIT      = 1;
    localparam int SSF_RBF_BIT      = 0;

    // reset values of the buffer level, busy and shift register empty flags
    localparam logic SSF_TBE_RESET  = 1'b1;
    localparam logic SSF_TBF_RESET  = 1'b0;
    localparam logic SSF_RBF_RESET  = 1'b0;
    localparam logic SSF_BUSY_RESET = 1'b0;
    localparam logic SSF_SHIFT_REG_EMPTY_FLAG_RESET = 1'b0;

    // control register layout
    localparam int SSF_CTRL_ON_BIT  = 0;
    localparam int SSF_CTRL_ENH_BIT = 1;
    localparam int SSF_CTRL_FRM_BIT = 2;
    localparam int SSF_CTRL_W       = 3;
    localparam logic [SSF_CTRL_W-1:0] SSF_CTRL_RESET = 3'h0;

    // interrupt event layout, shared by status, enable and clear
    localparam int SSF_IRQ_W        = 4;
    localparam int SSF_IRQ_FRM_BIT  = 0;
    localparam int SSF_IRQ_TUR_BIT  = 1;
    localparam int SSF_IRQ_ROV_BIT  = 2;
    localparam int SSF_IRQ_RXW_BIT  = 3;
    localparam logic [SSF_IRQ_W-1:0] SSF_IRQ_RESET = 4'h0;

    // fifo pointer width: depth 16 plus one wrap bit
    localparam int SSF_PTR_W        = 5;

endpackage : ssf_pkg

// file: core/ssf_sticky.sv
// sticky flag cell: hardware set wins over clear
`timescale 1ns/100ps
`default_nettype none

module ssf_sticky #(
    parameter int             W           = 1,
    parameter logic [W-1:0]   RESET_VALUE = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clear,
    output var  logic [W-1:0] q
);

    logic [W-1:0] next_q;

    // an event landing in the clearing cycle is kept
    assign next_q = (q & ~clear) | set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RESET_VALUE;
        end else begin
            q <= next_q;
        end
    end

endmodule // ssf_sticky

`default_nettype wire

// file: core/ssf_status.sv
// serial port status flags with apb register access and interrupt
// Notes on behaviour
// - receive element count at bits 28-24, valid only with enhanced buffer
// - transmit element count at bits 20-16, valid only with enhanced buffer
// - frame error flag at bit 12, set on detected frame error in framed mode
// - activity flag at bit 11 high while busy, low while idle
// - transmit underrun flag at bit 8, set in framed sync operation
// - underrun clears on module off then on, or software writing zero
// - bit 7 shows shift register empty, valid with enhanced buffer
// - receive overflow at bit 6 set, new word discarded if previous unread
// - overflow set only by hardware, cleared by off/on or writing zero
// - bit 5 shows receive fifo empty when read pointer equals write pointer, valid with enhanced buffer
// - unimplemented status bits read as zero
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module ssf_status
    import ssf_pkg::*;
#(
    parameter int PTR_W = SSF_PTR_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [PTR_W-1:0] rx_fifo_write_pointer,
    input  wire logic [PTR_W-1:0] rx_fifo_read_pointer,
    input  wire logic [PTR_W-1:0] tx_fifo_write_pointer,
    input  wire logic [PTR_W-1:0] tx_fifo_read_pointer,
    input  wire logic             frame_error_detect,
    input  wire logic             transfer_active,
    input  wire logic             tx_underrun_detect,
    input  wire logic             shift_reg_empty,
    input  wire logic             rx_word_done,
    input  wire logic             serial_data_buffer_unread,
    input  wire logic             tx_buffer_empty,
    input  wire logic             tx_buffer_full,
    input  wire logic             rx_buffer_full,
    output logic                  rx_word_keep,
    output logic                  module_on,
    output logic                  enhanced_buffer_enable,
    output logic                  framed_mode_enable,
    output logic                  irq
);

    // apb decode
    logic                  bus_setup;
    logic                  bus_access;
    logic                  bus_write;
    logic                  hit_status;
    logic                  hit_control;
    logic                  hit_irq_enable;
    logic                  hit_irq_clear;
    logic                  hit_irq_status;
    logic                  hit_any;

    // control and interrupt registers
    logic [SSF_CTRL_W-1:0] control;
    logic [SSF_IRQ_W-1:0]  irq_enable;
    logic [SSF_IRQ_W-1:0]  irq_status;
    logic [SSF_IRQ_W-1:0]  irq_set;
    logic [SSF_IRQ_W-1:0]  irq_clear;

    // hardware-set status flags: frame error, underrun, overflow
    logic [2:0]            flag_q;
    logic [2:0]            flag_set;
    logic [2:0]            flag_clear;
    logic                  frame_error_flag;
    logic                  tx_underrun_flag;
    logic                  rx_overflow_flag;

    // sampled level flags
    logic                  activity_flag;
    logic                  shift_reg_empty_q;
    logic                  tx_buffer_empty_flag;
    logic                  tx_buffer_full_flag;
    logic                  rx_buffer_full_flag;

    // derived status fields
    logic [PTR_W-1:0]      rx_ptr_diff;
    logic [PTR_W-1:0]      tx_ptr_diff;
    logic [SSF_CNT_W-1:0]  rx_element_count;
    logic [SSF_CNT_W-1:0]  tx_element_count;
    logic                  shift_reg_empty_flag;
    logic                  rx_fifo_empty_flag;
    logic                  overflow_event;
    logic [31:0]           serial_port_status;
    logic [31:0]           read_mux;
    logic [31:0]           next_prdata;

    // bus handshake: zero wait states, error on unmapped offsets
    assign bus_setup      = psel & ~penable;
    assign bus_access     = psel & penable;
    assign bus_write      = bus_access & pwrite;
    assign hit_status     = (paddr == SSF_ADDR_STATUS);
    assign hit_control    = (paddr == SSF_ADDR_CONTROL);
    assign hit_irq_enable = (paddr == SSF_ADDR_IRQ_ENABLE);
    assign hit_irq_clear  = (paddr == SSF_ADDR_IRQ_CLEAR);
    assign hit_irq_status = (paddr == SSF_ADDR_IRQ_STATUS);
    assign hit_any        = hit_status | hit_control | hit_irq_enable
                          | hit_irq_clear | hit_irq_status;
    assign pready         = 1'b1;
    assign pslverr        = bus_access & ~hit_any;

    // control outputs steer the rest of the unit
    assign module_on              = control[SSF_CTRL_ON_BIT];
    assign enhanced_buffer_enable = control[SSF_CTRL_ENH_BIT];
    assign framed_mode_enable     = control[SSF_CTRL_FRM_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= SSF_CTRL_RESET;
        end else if (bus_write && hit_control) begin
            control <= pwdata[SSF_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= SSF_IRQ_RESET;
        end else if (bus_write && hit_irq_enable) begin
            irq_enable <= pwdata[SSF_IRQ_W-1:0];
        end
    end

    // receive path: a finished word is kept only if the last was read
    assign overflow_event = rx_word_done & serial_data_buffer_unread & module_on;
    assign rx_word_keep   = rx_word_done & ~serial_data_buffer_unread & module_on;

    // flag sets; events are ignored while the module is off
    assign flag_set[0] = frame_error_detect & framed_mode_enable & module_on;
    assign flag_set[1] = tx_underrun_detect & framed_mode_enable & module_on;
    assign flag_set[2] = overflow_event;

    // software clears by writing zero; switching off clears all three,
    // so the off/on cycle leaves them clean when the module comes back
    assign flag_clear[0] = ~module_on
                         | (bus_write & hit_status & ~pwdata[SSF_FRAME_ERROR_FLAG_BIT]);
    assign flag_clear[1] = ~module_on
                         | (bus_write & hit_status & ~pwdata[SSF_TUR_BIT]);
    assign flag_clear[2] = ~module_on
                         | (bus_write & hit_status & ~pwdata[SSF_ROV_BIT]);

    ssf_sticky #(
        .W           (3),
        .RESET_VALUE (3'h0)
    ) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (flag_set),
        .clear   (flag_clear),
        .q       (flag_q)
    );

    assign frame_error_flag = flag_q[0];
    assign tx_underrun_flag = flag_q[1];
    assign rx_overflow_flag = flag_q[2];

    // level flags come from same-clock logic; one flop keeps reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            activity_flag        <= SSF_BUSY_RESET;
            shift_reg_empty_q    <= SSF_SHIFT_REG_EMPTY_FLAG_RESET;
            tx_buffer_empty_flag <= SSF_TBE_RESET;
            tx_buffer_full_flag  <= SSF_TBF_RESET;
            rx_buffer_full_flag  <= SSF_RBF_RESET;
        end else begin
            activity_flag        <= transfer_active;
            shift_reg_empty_q    <= shift_reg_empty;
            tx_buffer_empty_flag <= tx_buffer_empty;
            tx_buffer_full_flag  <= tx_buffer_full;
            rx_buffer_full_flag  <= rx_buffer_full;
        end
    end

    // element counts from the pointer distance; the wrap bit makes a full
    // fifo read as its depth rather than zero
    assign rx_ptr_diff = rx_fifo_write_pointer - rx_fifo_read_pointer;
    assign tx_ptr_diff = tx_fifo_write_pointer - tx_fifo_read_pointer;
    assign rx_element_count = enhanced_buffer_enable
                            ? SSF_CNT_W'(rx_ptr_diff) : '0;
    assign tx_element_count = enhanced_buffer_enable
                            ? SSF_CNT_W'(tx_ptr_diff) : '0;

    // enhanced-only flags read zero with the plain buffer
    assign shift_reg_empty_flag = enhanced_buffer_enable & shift_reg_empty_q;
    assign rx_fifo_empty_flag   = enhanced_buffer_enable
                                & (rx_fifo_read_pointer == rx_fifo_write_pointer);

    // status word; every position not assigned below reads zero
    always_comb begin
        serial_port_status = 32'h0000_0000;
        serial_port_status[SSF_RXCNT_LSB +: SSF_CNT_W] = rx_element_count;
        serial_port_status[SSF_TXCNT_LSB +: SSF_CNT_W] = tx_element_count;
        serial_port_status[SSF_FRAME_ERROR_FLAG_BIT] = frame_error_flag;
        serial_port_status[SSF_BUSY_BIT]   = activity_flag;
        serial_port_status[SSF_TUR_BIT]    = tx_underrun_flag;
        serial_port_status[SSF_SHIFT_REG_EMPTY_FLAG_BIT]   = shift_reg_empty_flag;
        serial_port_status[SSF_ROV_BIT]    = rx_overflow_flag;
        serial_port_status[SSF_RBE_BIT]    = rx_fifo_empty_flag;
        serial_port_status[SSF_TBE_BIT]    = tx_buffer_empty_flag;
        serial_port_status[SSF_TBF_BIT]    = tx_buffer_full_flag;
        serial_port_status[SSF_RBF_BIT]    = rx_buffer_full_flag;
    end

    // interrupt events share the flag set terms plus word arrival
    assign irq_set[SSF_IRQ_FRM_BIT] = flag_set[0];
    assign irq_set[SSF_IRQ_TUR_BIT] = flag_set[1];
    assign irq_set[SSF_IRQ_ROV_BIT] = flag_set[2];
    assign irq_set[SSF_IRQ_RXW_BIT] = rx_word_keep;
    assign irq_clear = (bus_write && hit_irq_clear) ? pwdata[SSF_IRQ_W-1:0] : '0;

    ssf_sticky #(
        .W           (SSF_IRQ_W),
        .RESET_VALUE (SSF_IRQ_RESET)
    ) u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (irq_set),
        .clear   (irq_clear),
        .q       (irq_status)
    );

    assign irq = |(irq_status & irq_enable);

    // read data is captured in the setup cycle, so it stands stable
    // through the access phase; the clear register reads zero
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_status) begin
            read_mux = serial_port_status;
        end else if (hit_control) begin
            read_mux[SSF_CTRL_W-1:0] = control;
        end else if (hit_irq_enable) begin
            read_mux[SSF_IRQ_W-1:0] = irq_enable;
        end else if (hit_irq_status) begin
            read_mux[SSF_IRQ_W-1:0] = irq_status;
        end
    end

    assign next_prdata = (bus_setup && !pwrite) ? read_mux : prdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

endmodule // ssf_status

`default_nettype wire

// file: verification/ssf_status_asserts.sv
// concurrent checks on the status flag block ports
`timescale 1ns/100ps
`default_nettype none
module ssf_status_asserts
    import ssf_pkg::*;
#(parameter int PTR_W = SSF_PTR_W) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic [7:0]       paddr,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [PTR_W-1:0] rx_fifo_write_pointer,
    input wire logic [PTR_W-1:0] rx_fifo_read_pointer,
    input wire logic [PTR_W-1:0] tx_fifo_write_pointer,
    input wire logic [PTR_W-1:0] tx_fifo_read_pointer,
    input wire logic             frame_error_detect,
    input wire logic             transfer_active,
    input wire logic             tx_underrun_detect,
    input wire logic             shift_reg_empty,
    input wire logic             rx_word_done,
    input wire logic             serial_data_buffer_unread,
    input wire logic             tx_buffer_empty,
    input wire logic             tx_buffer_full,
    input wire logic             rx_buffer_full,
    input wire logic             rx_word_keep,
    input wire logic             module_on,
    input wire logic             enhanced_buffer_enable,
    input wire logic             framed_mode_enable,
    input wire logic             irq
);
    // status read data is captured at setup, so pointers are one edge old
    wire logic rd_st  = psel & penable & ~pwrite & (paddr == SSF_ADDR_STATUS);
    wire logic ctl_wr = psel & penable & pwrite & (paddr == SSF_ADDR_CONTROL);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    word_keep_a: assert property (rx_word_keep ==
        (rx_word_done & ~serial_data_buffer_unread & module_on)) else $error("keep wrong");
    unused_zero_a: assert property (rd_st |-> (prdata & 32'hE0E0_E614) == 32'h0)
        else $error("unused bits set");
    rx_count_a: assert property (rd_st |-> prdata[28:24] == ($past(enhanced_buffer_enable) ?
        $past(rx_fifo_write_pointer) - $past(rx_fifo_read_pointer) : '0)) else $error("rx count");
    tx_count_a: assert property (rd_st |-> prdata[20:16] == ($past(enhanced_buffer_enable) ?
        $past(tx_fifo_write_pointer) - $past(tx_fifo_read_pointer) : '0)) else $error("tx count");
    rx_empty_a: assert property (rd_st |-> prdata[5] == ($past(enhanced_buffer_enable) &&
        $past(rx_fifo_write_pointer) == $past(rx_fifo_read_pointer))) else $error("rx empty");
    busy_flag_a: assert property (rd_st |-> prdata[11] == $past(transfer_active, 2))
        else $error("busy flag");
    shift_empty_a: assert property (rd_st |-> prdata[7] ==
        ($past(shift_reg_empty, 2) & $past(enhanced_buffer_enable))) else $error("shift empty");
    ctrl_write_a: assert property (!$stable({module_on, framed_mode_enable}) |-> $past(ctl_wr))
        else $error("control moved");
    irq_cause_a: assert property ($rose(irq) |-> $past(frame_error_detect |
        tx_underrun_detect | rx_word_done | (psel & penable & pwrite))) else $error("irq cause");
endmodule // ssf_status_asserts
bind ssf_status ssf_status_asserts #(.PTR_W(PTR_W)) chk (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_fifo_write_pointer(rx_fifo_write_pointer),
    .rx_fifo_read_pointer(rx_fifo_read_pointer), .tx_fifo_write_pointer(tx_fifo_write_pointer),
    .tx_fifo_read_pointer(tx_fifo_read_pointer), .frame_error_detect(frame_error_detect),
    .transfer_active(transfer_active), .tx_underrun_detect(tx_underrun_detect),
    .shift_reg_empty(shift_reg_empty), .rx_word_done(rx_word_done),
    .serial_data_buffer_unread(serial_data_buffer_unread), .tx_buffer_empty(tx_buffer_empty),
    .tx_buffer_full(tx_buffer_full), .rx_buffer_full(rx_buffer_full), .rx_word_keep(rx_word_keep),
    .module_on(module_on), .enhanced_buffer_enable(enhanced_buffer_enable),
    .framed_mode_enable(framed_mode_enable), .irq(irq));
`default_nettype wire

// file: verification/ssf_status_tb.sv
// self-checking bench for the serial port status flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module ssf_status_tb
    import ssf_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, kp;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [4:0]  rx_wp, rx_rp, tx_wp, tx_rp;
    logic        fed, act, tud, sre, rwd, unread, tbe, tbf, rbf, keep, mon, enh, frm, irq;
    int          err_count, compares;
    ssf_status dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_fifo_write_pointer(rx_wp), .rx_fifo_read_pointer(rx_rp),
        .tx_fifo_write_pointer(tx_wp), .tx_fifo_read_pointer(tx_rp), .frame_error_detect(fed),
        .transfer_active(act), .tx_underrun_detect(tud), .shift_reg_empty(sre),
        .rx_word_done(rwd), .serial_data_buffer_unread(unread), .tx_buffer_empty(tbe),
        .tx_buffer_full(tbf), .rx_buffer_full(rbf), .rx_word_keep(keep), .module_on(mon),
        .enhanced_buffer_enable(enh), .framed_mode_enable(frm), .irq(irq));
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // request held until pready is sampled high, no wait count assumed
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rdv, e)
    endtask
    // m = {frame error, underrun, word done}, one cycle wide
    task pulse(input logic [2:0] m);
        @(posedge pclk);
        {fed, tud, rwd} <= m;
        @(negedge pclk);
        kp = keep;
        @(posedge pclk);
        {fed, tud, rwd} <= 3'h0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        err_count++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, fed, act, tud, sre, rwd, unread, tbf, rbf} = '0;
        {paddr, pwdata, rx_wp, rx_rp, tx_wp, tx_rp, err_count, compares} = '0;
        tbe = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0008);
        rd_chk(SSF_ADDR_CONTROL, 32'h0);
        rd_chk(8'h14, 32'h0);
        `CHK(perr, 1'b1)
        `CHK(pready, 1'b1)
        $display("test reset done");
        xfer(1'b1, SSF_ADDR_CONTROL, 32'h3);
        {rx_wp, rx_rp, tx_wp, tx_rp} <= {5'h05, 5'h02, 5'h01, 5'h1F};
        {act, sre, tbe, tbf, rbf} <= 5'b11011;
        rd_chk(SSF_ADDR_STATUS, 32'h0302_0883);
        `CHK({mon, enh, frm}, 3'b110)
        rx_rp <= 5'h05;
        rd_chk(SSF_ADDR_STATUS, 32'h0002_08A3);
        xfer(1'b1, SSF_ADDR_CONTROL, 32'h1);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0803);
        `CHK({mon, enh, frm}, 3'b100)
        {act, sre, tbe, tbf, rbf} <= 5'b00100;
        $display("test counts done");
        xfer(1'b1, SSF_ADDR_IRQ_ENABLE, 32'h4);
        unread <= 1'b1;
        pulse(3'b001);
        `CHK(kp, 1'b0)
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0048);
        `CHK(irq, 1'b1)
        rd_chk(SSF_ADDR_IRQ_STATUS, 32'h0000_0004);
        rd_chk(SSF_ADDR_IRQ_ENABLE, 32'h0000_0004);
        xfer(1'b1, SSF_ADDR_STATUS, 32'hFFFF_FFFF);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0048);
        xfer(1'b1, SSF_ADDR_STATUS, 32'h0);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0008);
        xfer(1'b1, SSF_ADDR_IRQ_CLEAR, 32'h4);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        unread <= 1'b0;
        pulse(3'b001);
        `CHK(kp, 1'b1)
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0008);
        `CHK(irq, 1'b0)
        $display("test overflow done");
        pulse(3'b110);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0008);
        xfer(1'b1, SSF_ADDR_CONTROL, 32'h5);
        pulse(3'b110);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_1108);
        `CHK({mon, enh, frm}, 3'b101)
        rd_chk(SSF_ADDR_CONTROL, 32'h0000_0005);
        xfer(1'b1, SSF_ADDR_STATUS, 32'hFFFF_FEFF);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_1008);
        unread <= 1'b1;
        pulse(3'b011);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_1148);
        xfer(1'b1, SSF_ADDR_CONTROL, 32'h0);
        xfer(1'b1, SSF_ADDR_CONTROL, 32'h5);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0008);
        xfer(1'b1, SSF_ADDR_STATUS, 32'hFFFF_FFFF);
        rd_chk(SSF_ADDR_STATUS, 32'h0000_0008);
        $display("test framed done");
        end_of_test;
    end
endmodule // ssf_status_tb
`default_nettype wire
